/* core/tps_sequencer.sv */
// transmitter protection and turn-off sequencer with ahb-lite registers
// Behaviour
// - overload with second stage set forces plate off, hold-off running or not.
// - after trip-out plate stays off until a new plate-on command.
// - trip-out sets the sticky fault latch driving the fault lamp.
// - plate-on command clears the fault latch.
// - first overload starts the thirty second fault window.
// - window expiry clears both trip stages; three overloads needed.
// - plate-on command cancels a running fault window.
// - single-trip strap makes every overload latch the plate off.
// - each overload sets its lamp latch, cleared only by clear control.
// - internal interlock forces plate off; plate-on needed afterwards.
// - external interlock only gates plate enable; recovers by itself.
// - filament-off clears filament, plate off, resets warm-up, starts run-down.
// - run-down lasts three minutes then turns the blower off.
// - filament, blower, plate and fault latches survive an ac loss.
// - short outage with filaments on skips the warm-up on return.
// - outage over ten seconds runs the full warm-up before plate.
// - force-full-warm-up strap demands full warm-up after any outage.
// - outage during run-down restarts the full run-down on return.
// - each overload gives a three second hold-off removing plate enable.
// - hold-off ends set stage one, then stage two armed by one.
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module tps_sequencer
    import tps_pkg::*;
#(
    parameter int N_OVL = 4,
    parameter int unsigned TICK_CYCLES = TPS_TICK_CYCLES,
    parameter int unsigned HOLDOFF_TICKS = TPS_HOLDOFF_TICKS,
    parameter int unsigned WINDOW_TICKS = TPS_WINDOW_TICKS,
    parameter int unsigned RUNDOWN_TICKS = TPS_RUNDOWN_TICKS,
    parameter int unsigned WARMUP_TICKS = TPS_WARMUP_TICKS,
    parameter int unsigned OUTAGE_TICKS = TPS_OUTAGE_TICKS
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // operator and remote pins, active high
    input wire logic plate_on_in,
    input wire logic plate_off_in,
    input wire logic fil_on_in,
    input wire logic fil_off_in,
    input wire logic indicator_clear_switch_in,
    input wire logic int_interlock_in,
    input wire logic ext_interlock_in,
    input wire logic ac_power_ok_in,
    input wire logic single_trip_strap_in,
    input wire logic force_full_warmup_strap_in,
    input wire logic [N_OVL-1:0] overload_in,
    // relays and indicators
    output logic plate_enable_out,
    output logic filament_out,
    output logic blower_out,
    output logic fault_ind_out,
    output logic int_ilk_ind_out,
    output logic ext_ilk_ind_out,
    output logic [N_OVL-1:0] overload_ind_out,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int OW = $clog2(OUTAGE_TICKS + 2);

    typedef struct packed {
        logic [TPS_PIN_W-1:0] s1;
        logic [TPS_PIN_W-1:0] s2;
        logic [TPS_PIN_W-1:0] s3;
        logic [N_OVL-1:0] o1;
        logic [N_OVL-1:0] o2;
        logic [N_OVL-1:0] o3;
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic fil_latch;
        logic fil_ready;
        logic blower;
        logic plate_latch;
        logic fault_latch;
        logic trip1;
        logic trip2;
        logic [N_OVL-1:0] ovl_ind;
        logic plate_en;
        logic [OW-1:0] out_cnt;
        logic wr_pend;
        logic [3:0] wr_addr;
        logic [31:0] rdata;
    } tps_state_t;

    localparam tps_state_t ST_RST = '0;

    tps_state_t st_r;
    tps_state_t st_nxt;

    tps_tmr_if ho_if ();
    tps_tmr_if win_if ();
    tps_tmr_if wu_if ();
    tps_tmr_if bl_if ();

    logic [TPS_PIN_W-1:0] pins;
    logic [TPS_PIN_W-1:0] rise;
    logic [TPS_CMD_W-1:0] sw_cmd;
    logic ac_ok;
    logic ac_up;
    logic pon;
    logic poff;
    logic fon;
    logic foff;
    logic iclr;
    logic int_ilk;
    logic ext_ilk;
    logic strip;
    logic sfull;
    logic [N_OVL-1:0] ovl_rise;
    logic ovl_evt;
    logic trip_evt;
    logic off_any;
    logic short_out;
    logic take;
    logic [TPS_ST_W-1:0] status;

    // gather the asynchronous pins into one vector
    assign pins = {force_full_warmup_strap_in, single_trip_strap_in, ac_power_ok_in,
                   ext_interlock_in, int_interlock_in, indicator_clear_switch_in,
                   fil_off_in, fil_on_in, plate_off_in, plate_on_in};

    // ****************************************
    // timers
    // ****************************************
    tps_timer #(.PERIOD(HOLDOFF_TICKS)) u_holdoff (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
        .tick_in(st_r.tick), .t(ho_if.tmr_mp));
    tps_timer #(.PERIOD(WINDOW_TICKS)) u_window (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
        .tick_in(st_r.tick), .t(win_if.tmr_mp));
    tps_timer #(.PERIOD(WARMUP_TICKS)) u_warmup (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
        .tick_in(st_r.tick), .t(wu_if.tmr_mp));
    tps_timer #(.PERIOD(RUNDOWN_TICKS)) u_rundown (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
        .tick_in(st_r.tick), .t(bl_if.tmr_mp));

    // ****************************************
    // decoded events from synchronised pins and software
    // ****************************************
    always_comb begin
        rise = st_r.s2 & ~st_r.s3;
        ovl_rise = st_r.o2 & ~st_r.o3;
        ac_ok = st_r.s2[TPS_PIN_ACOK];
        ac_up = rise[TPS_PIN_ACOK];
        sw_cmd = '0;
        if (st_r.wr_pend && st_r.wr_addr == TPS_REG_CMD) begin
            sw_cmd = hwdata_in[TPS_CMD_W-1:0];
        end
        // plate and filament controls are dead while ac power is away
        pon = ac_ok && (rise[TPS_PIN_PON] || sw_cmd[TPS_CMD_PON]);
        poff = ac_ok && (rise[TPS_PIN_POFF] || sw_cmd[TPS_CMD_POFF]);
        fon = ac_ok && (rise[TPS_PIN_FON] || sw_cmd[TPS_CMD_FON]);
        foff = ac_ok && (rise[TPS_PIN_FOFF] || sw_cmd[TPS_CMD_FOFF]);
        iclr = st_r.s2[TPS_PIN_ICLR] || sw_cmd[TPS_CMD_ICLR];
        int_ilk = st_r.s2[TPS_PIN_IILK];
        ext_ilk = st_r.s2[TPS_PIN_EILK];
        strip = st_r.s2[TPS_PIN_STRIP];
        sfull = st_r.s2[TPS_PIN_SFULL];
        ovl_evt = ac_ok && (|ovl_rise);
        trip_evt = ovl_evt && (st_r.trip2 || strip);
        off_any = poff || trip_evt || foff || (ac_ok && int_ilk);
        short_out = (st_r.out_cnt <= OW'(OUTAGE_TICKS)) && !sfull;
        take = hsel_in && htrans_in[1] && hready_in;
    end

    // status word seen by software
    always_comb begin
        status = '0;
        status[TPS_ST_PLATE] = st_r.plate_latch;
        status[TPS_ST_FIL] = st_r.fil_latch;
        status[TPS_ST_READY] = st_r.fil_ready;
        status[TPS_ST_BLOWER] = st_r.blower;
        status[TPS_ST_FAULT] = st_r.fault_latch;
        status[TPS_ST_TRIP1] = st_r.trip1;
        status[TPS_ST_TRIP2] = st_r.trip2;
        status[TPS_ST_EN] = st_r.plate_en;
        status[TPS_ST_ACOK] = ac_ok;
    end

    // ****************************************
    // timer controls
    // ****************************************
    always_comb begin
        ho_if.start = ovl_evt;
        ho_if.clear = !ac_ok;
        win_if.start = ovl_evt && !win_if.busy;
        win_if.clear = pon || !ac_ok;
        wu_if.start = 1'b0;
        wu_if.clear = foff || !ac_ok;
        bl_if.start = foff;
        bl_if.clear = !ac_ok;
        if ((fon || pon) && !foff && !st_r.fil_latch) begin
            wu_if.start = 1'b1;
            bl_if.clear = 1'b1;
        end
        if (ac_up && st_r.fil_latch && !(short_out && st_r.fil_ready)) begin
            wu_if.start = 1'b1;
        end
        if (ac_up && st_r.blower && !st_r.fil_latch) begin
            bl_if.start = 1'b1;
        end
    end

    // ****************************************
    // sequencer next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.o1 = overload_in;
        st_nxt.o2 = st_r.o1;
        st_nxt.o3 = st_r.o2;
        // common tick
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + TW'(1);
        end
        // plate latch, off beats on
        if (off_any) begin
            st_nxt.plate_latch = 1'b0;
        end else if (pon) begin
            st_nxt.plate_latch = 1'b1;
        end
        // fault latch, trip beats clear
        if (trip_evt) begin
            st_nxt.fault_latch = 1'b1;
        end else if (pon) begin
            st_nxt.fault_latch = 1'b0;
        end
        // filament and blower
        if (foff) begin
            st_nxt.fil_latch = 1'b0;
            st_nxt.fil_ready = 1'b0;
        end else if ((fon || pon) && !st_r.fil_latch) begin
            st_nxt.fil_latch = 1'b1; // plate-on also starts filaments
            st_nxt.fil_ready = 1'b0;
            st_nxt.blower = 1'b1;
        end else if (wu_if.done) begin
            st_nxt.fil_ready = 1'b1;
        end
        if (bl_if.done && !st_r.fil_latch) begin
            st_nxt.blower = 1'b0;
        end
        // trip stages
        if (ho_if.done) begin
            if (st_r.trip1) begin
                st_nxt.trip2 = 1'b1;
            end
            st_nxt.trip1 = 1'b1;
        end
        if (win_if.done || pon) begin // plate-on ends the window early as well
            st_nxt.trip1 = 1'b0;
            st_nxt.trip2 = 1'b0;
        end
        // lamp latches, a new overload beats the clear
        if (iclr) begin
            st_nxt.ovl_ind = ac_ok ? ovl_rise : '0;
        end else if (ac_ok) begin
            st_nxt.ovl_ind = st_r.ovl_ind | ovl_rise;
        end
        // outage timing; latches are simply left alone
        if (!ac_ok) begin
            if (st_r.tick && st_r.out_cnt <= OW'(OUTAGE_TICKS)) begin
                st_nxt.out_cnt = st_r.out_cnt + OW'(1);
            end
        end else begin
            st_nxt.out_cnt = '0;
        end
        if (ac_up && st_r.fil_latch && !(short_out && st_r.fil_ready)) begin
            st_nxt.fil_ready = 1'b0;
        end
        // plate gate
        st_nxt.plate_en = ac_ok && st_nxt.plate_latch && st_nxt.fil_latch &&
                          st_nxt.fil_ready && !ho_if.busy && !ho_if.start &&
                          !ext_ilk && !int_ilk;
        // bus: address phase, then data phase
        st_nxt.wr_pend = take && hwrite_in;
        st_nxt.wr_addr = haddr_in[3:0];
        st_nxt.rdata = '0;
        if (take && !hwrite_in && haddr_in[31:4] == '0) begin
            case (haddr_in[3:0])
                TPS_REG_STATUS: st_nxt.rdata = 32'(status);
                TPS_REG_OVL: st_nxt.rdata = 32'(st_r.ovl_ind);
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (haddr_in[31:4] != '0) begin
            st_nxt.wr_pend = 1'b0; // unmapped writes are dropped
        end
    end

    // state register, frozen while enable is low
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= ST_RST;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign plate_enable_out = st_r.plate_en;
    assign filament_out = st_r.fil_latch && st_r.s2[TPS_PIN_ACOK];
    assign blower_out = st_r.blower && st_r.s2[TPS_PIN_ACOK];
    assign fault_ind_out = st_r.fault_latch;
    assign int_ilk_ind_out = st_r.s2[TPS_PIN_IILK];
    assign ext_ilk_ind_out = st_r.s2[TPS_PIN_EILK];
    assign overload_ind_out = st_r.ovl_ind;
    assign hrdata_out = st_r.rdata;
    assign hreadyout_out = ce_in; // bus waits while frozen
    assign hresp_out = 1'b0;

    // ****************************************
    // assertions
    // ****************************************
    AST_TRIP_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && trip_evt |=> !st_r.plate_latch && !plate_enable_out)
        else $error("trip-out did not drop the plate");
    AST_STAY_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st_r.plate_latch && !(ce_in && pon) |=> !st_r.plate_latch)
        else $error("plate came back without plate-on");
    AST_FAULT_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && trip_evt |=> fault_ind_out)
        else $error("trip-out did not set fault lamp");
    AST_FAULT_CLR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && pon && !trip_evt |=> !fault_ind_out)
        else $error("plate-on did not clear fault");
    AST_WIN_CLR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && win_if.done |=> !st_r.trip1 && !st_r.trip2)
        else $error("window end left a trip stage set");
    AST_WIN_RESET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && pon |=> !win_if.busy)
        else $error("plate-on left fault window running");
    AST_IND_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(ce_in && iclr) |=> (st_r.ovl_ind & $past(st_r.ovl_ind)) == $past(st_r.ovl_ind))
        else $error("overload lamp lost without clear");
    AST_EXT_GATE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && ext_ilk |=> !plate_enable_out)
        else $error("external interlock did not gate plate");
    AST_FIL_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && foff |=> !st_r.fil_latch && !st_r.plate_latch && bl_if.busy && !wu_if.busy)
        else $error("filament-off sequence incomplete");
    AST_HOLDOFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ce_in && ovl_evt |=> !plate_enable_out ##1 (!ce_in || ho_if.busy))
        else $error("hold-off did not remove plate enable");
endmodule : tps_sequencer

/* core/tps_pkg.sv */
// constants shared by the transmitter protection sequencer files
package tps_pkg;
    // ****************************************
    // clock and timer base
    // ****************************************
    localparam int unsigned TPS_CLK_HZ = 10_000_000;
    localparam int unsigned TPS_TICK_MS = 10;
    localparam int unsigned TPS_TICK_CYCLES = TPS_CLK_HZ / 1000 * TPS_TICK_MS;
    localparam int unsigned TPS_HOLDOFF_MS = 3000;
    localparam int unsigned TPS_WINDOW_MS = 30000;
    localparam int unsigned TPS_RUNDOWN_MS = 180000;
    localparam int unsigned TPS_WARMUP_MS = 20000;
    localparam int unsigned TPS_OUTAGE_MS = 10000;
    localparam int unsigned TPS_HOLDOFF_TICKS = TPS_HOLDOFF_MS / TPS_TICK_MS;
    localparam int unsigned TPS_WINDOW_TICKS = TPS_WINDOW_MS / TPS_TICK_MS;
    localparam int unsigned TPS_RUNDOWN_TICKS = TPS_RUNDOWN_MS / TPS_TICK_MS;
    localparam int unsigned TPS_WARMUP_TICKS = TPS_WARMUP_MS / TPS_TICK_MS;
    localparam int unsigned TPS_OUTAGE_TICKS = TPS_OUTAGE_MS / TPS_TICK_MS;
    // ****************************************
    // register map and fields
    // ****************************************
    localparam logic [3:0] TPS_REG_CMD = 4'h0;
    localparam logic [3:0] TPS_REG_STATUS = 4'h4;
    localparam logic [3:0] TPS_REG_OVL = 4'h8;
    localparam int TPS_CMD_PON = 0;
    localparam int TPS_CMD_POFF = 1;
    localparam int TPS_CMD_FON = 2;
    localparam int TPS_CMD_FOFF = 3;
    localparam int TPS_CMD_ICLR = 4;
    localparam int TPS_CMD_W = 5;
    localparam int TPS_ST_PLATE = 0;
    localparam int TPS_ST_FIL = 1;
    localparam int TPS_ST_READY = 2;
    localparam int TPS_ST_BLOWER = 3;
    localparam int TPS_ST_FAULT = 4;
    localparam int TPS_ST_TRIP1 = 5;
    localparam int TPS_ST_TRIP2 = 6;
    localparam int TPS_ST_EN = 7;
    localparam int TPS_ST_ACOK = 8;
    localparam int TPS_ST_W = 9;
    localparam logic TPS_LATCH_RST = 1'b0;
    // ****************************************
    // synchronised pin vector layout
    // ****************************************
    localparam int TPS_PIN_PON = 0;
    localparam int TPS_PIN_POFF = 1;
    localparam int TPS_PIN_FON = 2;
    localparam int TPS_PIN_FOFF = 3;
    localparam int TPS_PIN_ICLR = 4;
    localparam int TPS_PIN_IILK = 5;
    localparam int TPS_PIN_EILK = 6;
    localparam int TPS_PIN_ACOK = 7;
    localparam int TPS_PIN_STRIP = 8;
    localparam int TPS_PIN_SFULL = 9;
    localparam int TPS_PIN_W = 10;
endpackage : tps_pkg

/* core/tps_tmr_if.sv */
// control and status signals between the sequencer and one timer
`timescale 1ns/1ps
interface tps_tmr_if;
    logic start;
    logic clear;
    logic busy;
    logic done;
    modport ctl_mp (output start, output clear, input busy, input done);
    modport tmr_mp (input start, input clear, output busy, output done);
endinterface : tps_tmr_if

/* core/tps_timer.sv */
// retriggerable one-shot timer counting common ticks
`timescale 1ns/1ps
module tps_timer
    import tps_pkg::*;
#(
    parameter int unsigned PERIOD = 300
) (
    // clock, reset, enable
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic tick_in,
    // control from the sequencer
    tps_tmr_if.tmr_mp t
);
    localparam int W = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic done;
    } tps_tmr_st_t;

    localparam tps_tmr_st_t TMR_RST = '0;

    tps_tmr_st_t st_r;
    tps_tmr_st_t st_nxt;

    // ****************************************
    // next state: clear beats start
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (t.clear) begin
            st_nxt.busy = 1'b0;
            st_nxt.cnt = '0;
        end else if (t.start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = W'(PERIOD);
        end else if (st_r.busy && tick_in) begin
            if (st_r.cnt == W'(1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1; // one-cycle end pulse
            end
            st_nxt.cnt = st_r.cnt - W'(1);
        end
    end

    // state register, frozen while enable is low
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_r <= TMR_RST;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign t.busy = st_r.busy;
    assign t.done = st_r.done;
endmodule : tps_timer

/* tb/tps_field_model.sv */
// operator panel, interlock switches, straps and overload detectors
`timescale 1ns/1ps
module tps_field_model
    import tps_pkg::*;
(
    // clock
    input wire logic clk_sys_in,
    // pin levels towards the sequencer, overloads above the named pins
    output logic [TPS_PIN_W+3:0] pins_out
);
    logic [TPS_PIN_W+3:0] lv_r = '0;
    // levels only move just after a rising edge, like a real switch panel
    assign pins_out = lv_r;
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk_sys_in);
        lv_r[idx] <= v;
    endtask : set_pin
endmodule : tps_field_model

/* tb/tps_sequencer_tb.sv */
// self-checking bench for the transmitter protection sequencer
`timescale 1ns/1ps
module tps_sequencer_tb
    import tps_pkg::*;
;
    localparam int P = TPS_PIN_W;
    logic clk = 1'b0;
    logic rst_in = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [P+3:0] pins;
    logic plate, fil, blower, fault, iind, eind, hready, hresp;
    logic [3:0] ovl_ind;
    int fails = 0;
    int cmp_count = 0;
    // 10 MHz system clock
    always #50 clk = ~clk;
    tps_field_model u_tps_field_model (.clk_sys_in(clk), .pins_out(pins));
    // short timer periods keep the run brief: tick of 4 cycles
    tps_sequencer #(.TICK_CYCLES(4), .HOLDOFF_TICKS(5), .WINDOW_TICKS(40),
        .RUNDOWN_TICKS(20), .WARMUP_TICKS(10), .OUTAGE_TICKS(8)) u_tps_sequencer (
        .clk_sys_in(clk),
        .rst_in(rst_in),
        .ce_in(ce),
        .plate_on_in(pins[TPS_PIN_PON]),
        .plate_off_in(pins[TPS_PIN_POFF]),
        .fil_on_in(pins[TPS_PIN_FON]),
        .fil_off_in(pins[TPS_PIN_FOFF]),
        .indicator_clear_switch_in(pins[TPS_PIN_ICLR]),
        .int_interlock_in(pins[TPS_PIN_IILK]),
        .ext_interlock_in(pins[TPS_PIN_EILK]),
        .ac_power_ok_in(pins[TPS_PIN_ACOK]),
        .single_trip_strap_in(pins[TPS_PIN_STRIP]),
        .force_full_warmup_strap_in(pins[TPS_PIN_SFULL]),
        .overload_in(pins[P+3:P]),
        .plate_enable_out(plate),
        .filament_out(fil),
        .blower_out(blower),
        .fault_ind_out(fault),
        .int_ilk_ind_out(iind),
        .ext_ilk_ind_out(eind),
        .overload_ind_out(ovl_ind),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(3'h2),
        .hwdata_in(hwdata),
        .hready_in(hready),
        .hrdata_out(hrdata),
        .hreadyout_out(hready),
        .hresp_out(hresp)
    );
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic pin(input int i, input logic v);
        u_tps_field_model.set_pin(i, v);
    endtask : pin
    // a pin pulse held long enough for the synchroniser
    task automatic pulse(input int i);
        pin(i, 1'b1);
        repeat (3) @(posedge clk);
        pin(i, 1'b0);
    endtask : pulse
    // one ahb-lite single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check("hresp", 0, hresp);
    endtask : bus
    // plate (w=0) or blower (w=1) must reach exp after lo..hi cycles; lo>hi: never
    task automatic wait_out(input string nm, input bit w, input logic exp, input int lo,
        input int hi);
        int c = 0;
        while (c <= hi && (w ? blower : plate) !== exp) begin
            @(posedge clk);
            c++;
        end
        cmp_count++;
        if ((c <= hi) != (lo <= hi) || (c <= hi && c < lo)) begin
            fails++;
            $display("FAIL %s expected %0d in %0d..%0d seen at %0d", nm, exp, lo, hi, c);
        end
    endtask : wait_out
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // watchdog against a hung handshake or timer
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        pin(TPS_PIN_ACOK, 1'b1);
        repeat (7) @(posedge clk);
        rst_in <= 1'b0;
        check("plate at reset", 0, plate);
        bus(1'b0, 32'hC, 32'h0);
        check("unmapped read", 0, rd);
        bus(1'b1, TPS_REG_CMD, 32'h1);
        wait_out("one button start", 0, 1, 30, 100);
        check("blower on", 1, blower);
        // three overloads inside the window latch the plate off
        for (int i = 0; i < 3; i++) begin
            pulse(P + i);
            wait_out("hold-off drop", 0, 0, 0, 10);
            wait_out("hold-off end", 0, 1, (i < 2) ? 10 : 61, 60);
        end
        check("fault lamp", 1, fault);
        bus(1'b0, TPS_REG_OVL, 32'h0);
        check("lamps", 32'h7, rd);
        pulse(TPS_PIN_ICLR);
        repeat (5) @(posedge clk);
        check("lamps cleared", 0, ovl_ind);
        bus(1'b1, TPS_REG_CMD, 32'h1);
        wait_out("plate-on after trip", 0, 1, 0, 20);
        check("fault cleared", 0, fault);
        // a lone overload is forgotten when the window runs out
        pulse(P);
        wait_out("hold-off end", 0, 1, 10, 40);
        repeat (200) @(posedge clk);
        bus(1'b0, TPS_REG_STATUS, 32'h0);
        check("trips after window", 0, rd[TPS_ST_TRIP2:TPS_ST_TRIP1]);
        for (int i = 0; i < 2; i++) begin
            pulse(P + 1);
            wait_out("no trip", 0, 1, 10, 40);
        end
        bus(1'b0, TPS_REG_STATUS, 32'h0);
        check("stage two", 1, rd[TPS_ST_TRIP2]);
        repeat (200) @(posedge clk);
        pin(TPS_PIN_STRIP, 1'b1);
        pulse(P + 3);
        wait_out("single trip", 0, 1, 61, 60);
        pin(TPS_PIN_STRIP, 1'b0);
        pulse(TPS_PIN_PON);
        wait_out("pin plate-on", 0, 1, 0, 20);
        // internal interlock needs a command, external one recovers alone
        pin(TPS_PIN_IILK, 1'b1);
        wait_out("int interlock", 0, 0, 0, 10);
        check("int lamp", 1, iind);
        pin(TPS_PIN_IILK, 1'b0);
        wait_out("stay off", 0, 1, 41, 40);
        bus(1'b1, TPS_REG_CMD, 32'h1);
        wait_out("plate back", 0, 1, 0, 20);
        pin(TPS_PIN_EILK, 1'b1);
        wait_out("ext interlock", 0, 0, 0, 10);
        check("ext lamp", 1, eind);
        pin(TPS_PIN_EILK, 1'b0);
        wait_out("auto return", 0, 1, 0, 20);
        // plate-off pin drops the plate until a fresh plate-on
        pulse(TPS_PIN_POFF);
        wait_out("pin plate-off", 0, 0, 0, 10);
        wait_out("plate-off holds", 0, 1, 41, 40);
        bus(1'b1, TPS_REG_CMD, 32'h1);
        wait_out("plate after off", 0, 1, 0, 20);
        // short, long and strapped outages
        for (int i = 0; i < 3; i++) begin
            pin(TPS_PIN_SFULL, i == 2);
            pin(TPS_PIN_ACOK, 1'b0);
            repeat ((i == 1) ? 60 : 10) @(posedge clk);
            pin(TPS_PIN_ACOK, 1'b1);
            wait_out("outage", 0, 1, i ? 30 : 0, i ? 80 : 20);
            check("filament kept", 1, fil);
        end
        pin(TPS_PIN_SFULL, 1'b0);
        // filament off, then an outage in mid run-down
        bus(1'b1, TPS_REG_CMD, 32'h1 << TPS_CMD_FOFF);
        wait_out("fil-off plate", 0, 0, 0, 10);
        bus(1'b0, TPS_REG_STATUS, 32'h0);
        check("fil latch", 0, rd[TPS_ST_FIL]);
        check("warm-up reset", 0, rd[TPS_ST_READY]);
        check("blower runs", 1, blower);
        // a long freeze must neither end the run-down nor answer the bus
        ce <= 1'b0;
        repeat (100) @(posedge clk);
        check("bus stalls", 0, hready);
        ce <= 1'b1;
        check("run-down frozen", 1, blower);
        pin(TPS_PIN_ACOK, 1'b0);
        repeat (10) @(posedge clk);
        pin(TPS_PIN_ACOK, 1'b1);
        repeat (6) @(posedge clk);
        wait_out("run-down restart", 1, 0, 60, 120);
        // filament-on pin relights filaments and blower
        pulse(TPS_PIN_FON);
        check("pin fil-on", 1, fil);
        check("fil-on blower", 1, blower);
        report_and_stop();
    end
endmodule : tps_sequencer_tb
